// >>> dfcm_pkg.sv
// constants and types for the drive fault code monitor
package dfcm_pkg;

  // fault codes shown on the diagnostic indicator
  localparam logic [7:0] CODE_NONE        = 8'h00;
  localparam logic [7:0] CODE_CTL_CHECK2  = 8'h12;
  localparam logic [7:0] CODE_OFF_TRACK   = 8'h13;
  localparam logic [7:0] CODE_UNSAFE      = 8'h14;
  localparam logic [7:0] CODE_PROTECT     = 8'h15;
  localparam logic [7:0] CODE_MULTI_HEAD  = 8'h16;
  localparam logic [7:0] CODE_RTZ_TIMEOUT = 8'h21;
  localparam logic [7:0] CODE_SEEK_TMO    = 8'h22;
  localparam logic [7:0] CODE_NOT_SPEED   = 8'h23;
  localparam logic [7:0] CODE_SEEK_GUARD  = 8'h24;
  localparam logic [7:0] CODE_LIN_GUARD   = 8'h25;
  localparam logic [7:0] CODE_ILLEGAL_CYL = 8'h27;
  localparam logic [7:0] CODE_OVERSHOOT   = 8'h2B;

  // cylinder limit and off-track threshold (fine position in volts, unsigned magnitude)
  localparam logic [9:0] MAX_CYLINDER     = 10'h2E8;   // 744
  localparam int         OFF_TRACK_MV     = 92000;     // 92 V zero-to-peak in mV
  localparam int         FPE_LSB_MV       = 1000;      // one lsb of sampled error = 1 V
  localparam logic [7:0] OFF_TRACK_LSB    = 8'(OFF_TRACK_MV / FPE_LSB_MV);

  // timing
  localparam longint CLK_HZ               = 125000000;
  localparam longint RTZ_TIMEOUT_MS       = 2000;
  localparam longint SEEK_TIMEOUT_MS      = 200;
  localparam longint RTZ_TIMEOUT_CYC      = RTZ_TIMEOUT_MS * CLK_HZ / 1000;
  localparam longint SEEK_TIMEOUT_CYC     = SEEK_TIMEOUT_MS * CLK_HZ / 1000;

  // register offsets
  localparam logic [3:0] REG_CONTROL      = 4'h0;
  localparam logic [3:0] REG_CODE         = 4'h1;
  localparam logic [3:0] REG_STATUS       = 4'h2;
  localparam logic [3:0] REG_CLEAR        = 4'h3;
  localparam logic [3:0] REG_ENABLE       = 4'h4;
  localparam logic [3:0] REG_CYLINDER     = 4'h5;

  // reset values
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] ENABLE_RESET     = 8'h00;

  // status bit positions
  localparam int ST_DEV_CHECK             = 0;
  localparam int ST_SEEK_ERR              = 1;

  // positioner activity
  typedef enum logic [2:0] {
    DFCM_IDLE = 3'b001,
    DFCM_SEEK = 3'b010,
    DFCM_RTZ  = 3'b100
  } dfcm_pos_type;

endpackage : dfcm_pkg

// >>> dfcm_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
module dfcm_sync #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;   // first stage, read only by the second

  // plain two-stage crossing
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule // dfcm_sync

// >>> dfcm_monitor.sv
// fault detection and fault code reporting for the drive
// What this block does
// - illegal read/write order gives code 12
// - off-track beyond 92 V in write: 13
// - write driver fault gives code 14
// - write while protected refused, code 15
// - multiple heads during write gives 16
// - return to zero over 2 s: 21
// - seek over 200 ms gives 22
// - overshoot onto wrong cylinder in linear mode gives 2B
// - seek without speed good gives 23
// - guard band during seek gives 24
// - guard band in linear mode: 25
// - cylinder address above 744 gives 27
// - write during read or offset: 12
// - indicator outputs show fault group
// - seek not ended in time: 22
module dfcm_monitor #(
  parameter longint RTZ_CYC  = dfcm_pkg::RTZ_TIMEOUT_CYC,
  parameter longint SEEK_CYC = dfcm_pkg::SEEK_TIMEOUT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // commands from the controller (same clock domain, one-cycle pulses)
  input  wire logic        seek_cmd_i,
  input  wire logic        rtz_cmd_i,
  input  wire logic        read_cmd_i,
  input  wire logic        write_cmd_i,
  input  wire logic [9:0]  cylinder_address_register_i,
  // drive status pins, asynchronous
  input  wire logic        write_active_i,
  input  wire logic        read_active_i,
  input  wire logic        offset_active_i,
  input  wire logic        ready_i,
  input  wire logic        on_cylinder_i,
  input  wire logic        write_unsafe_i,
  input  wire logic        file_protect_i,
  input  wire logic        multi_head_i,
  input  wire logic        speed_good_i,
  input  wire logic        guard_band_i,
  input  wire logic        linear_mode_i,
  input  wire logic        seek_done_i,
  input  wire logic        overshoot_i,
  // fine position error magnitude sample, same domain, volts
  input  wire logic [7:0]  fine_position_error_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // results
  output logic      [7:0]  fault_code_o,
  output logic             device_check_status_o,
  output logic             seek_error_status_o,
  output logic             write_refused_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // pin crossing
  // ---------------------------------------------------------------
  logic [12:0] pins_raw;
  logic [12:0] pins_s;

  assign pins_raw = {write_active_i, read_active_i, offset_active_i, ready_i,
                     on_cylinder_i, write_unsafe_i, file_protect_i, multi_head_i,
                     speed_good_i, guard_band_i, linear_mode_i, seek_done_i,
                     overshoot_i};

  dfcm_sync #(.W(13)) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  wire wr_act  = pins_s[12];  // write operation in progress
  wire rd_act  = pins_s[11];  // read operation in progress
  wire ofs_act = pins_s[10];  // offset applied
  wire rdy     = pins_s[9];
  wire on_cyl  = pins_s[8];
  wire unsafe  = pins_s[7];
  wire protect = pins_s[6];
  wire multi   = pins_s[5];
  wire spd_ok  = pins_s[4];
  wire guard   = pins_s[3];
  wire linear  = pins_s[2];
  wire done    = pins_s[1];
  wire ovs     = pins_s[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]          code_reg;     // latched first fault code
  logic [7:0]          code_next;
  logic [1:0]          status_reg;   // sticky device check / seek error
  logic [1:0]          status_next;
  logic [1:0]          enable_reg;   // interrupt enables
  logic [7:0]          control_reg;  // bit0: code clear strobe, bit1: cyl check mask
  logic [7:0]          rdata_reg;
  dfcm_pkg::dfcm_pos_type pos_reg;   // positioner activity
  dfcm_pkg::dfcm_pos_type pos_next;
  logic [31:0]         timer_reg;    // seek / rtz elapsed cycles
  logic [31:0]         timer_next;
  logic                seek_err_reg; // seek error condition blocks read/write

  // ---------------------------------------------------------------
  // decode of the register port
  // ---------------------------------------------------------------
  wire wr_control = wr_i && (addr_i == dfcm_pkg::REG_CONTROL);
  wire wr_clear   = wr_i && (addr_i == dfcm_pkg::REG_CLEAR);
  wire wr_enable  = wr_i && (addr_i == dfcm_pkg::REG_ENABLE);
  // writing bit 0 of control drops the held code so a new one can be caught
  wire code_clear = wr_control && wdata_i[0];
  wire cyl_check  = !control_reg[1];   // set bit 1 to mask the cylinder check

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux = (addr_i == dfcm_pkg::REG_CONTROL)  ? control_reg :
                  (addr_i == dfcm_pkg::REG_CODE)     ? code_reg :
                  (addr_i == dfcm_pkg::REG_STATUS)   ? {6'h00, status_reg} :
                  (addr_i == dfcm_pkg::REG_ENABLE)   ? {6'h00, enable_reg} :
                  (addr_i == dfcm_pkg::REG_CYLINDER) ? cylinder_address_register_i[7:0] :
                  8'h00;

  // ---------------------------------------------------------------
  // fault detection
  // ---------------------------------------------------------------
  // a read or write is illegal under seek error, not ready or off cylinder
  wire rw_cmd      = read_cmd_i || write_cmd_i;
  wire rw_bad_st   = seek_err_reg || !rdy || !on_cyl;
  wire det_ctl12   = (rw_cmd && rw_bad_st) ||
                     (write_cmd_i && (rd_act || ofs_act));
  wire det_offtrk  = wr_act && (fine_position_error_i > dfcm_pkg::OFF_TRACK_LSB);
  wire det_unsafe  = wr_act && unsafe;
  wire det_protect = write_cmd_i && protect;
  wire det_multi   = wr_act && multi;
  wire timer_full  = (pos_reg == dfcm_pkg::DFCM_RTZ) ? (64'(timer_reg) >= RTZ_CYC - 1) :
                                             (64'(timer_reg) >= SEEK_CYC - 1);
  wire det_rtz_to  = (pos_reg == dfcm_pkg::DFCM_RTZ) && !done && timer_full;
  wire det_seek_to = (pos_reg == dfcm_pkg::DFCM_SEEK) && !done && timer_full;
  wire det_ovs     = linear && ovs;
  wire det_nspd    = seek_cmd_i && !spd_ok;
  wire det_sgb     = (pos_reg != dfcm_pkg::DFCM_IDLE) && guard;
  wire det_lgb     = (pos_reg == dfcm_pkg::DFCM_IDLE) && linear && guard;
  wire det_cyl     = cyl_check &&
                     (cylinder_address_register_i > dfcm_pkg::MAX_CYLINDER);

  // priority: device checks before seek errors, lower code first except overshoot 2B ahead of 23, 24, 25 and 27
  logic [7:0] new_code;
  assign new_code = det_ctl12   ? dfcm_pkg::CODE_CTL_CHECK2  :
                    det_offtrk  ? dfcm_pkg::CODE_OFF_TRACK   :
                    det_unsafe  ? dfcm_pkg::CODE_UNSAFE      :
                    det_protect ? dfcm_pkg::CODE_PROTECT     :
                    det_multi   ? dfcm_pkg::CODE_MULTI_HEAD  :
                    det_rtz_to  ? dfcm_pkg::CODE_RTZ_TIMEOUT :
                    det_seek_to ? dfcm_pkg::CODE_SEEK_TMO    :
                    det_ovs     ? dfcm_pkg::CODE_OVERSHOOT   :
                    det_nspd    ? dfcm_pkg::CODE_NOT_SPEED   :
                    det_sgb     ? dfcm_pkg::CODE_SEEK_GUARD  :
                    det_lgb     ? dfcm_pkg::CODE_LIN_GUARD   :
                    det_cyl     ? dfcm_pkg::CODE_ILLEGAL_CYL :
                    dfcm_pkg::CODE_NONE;

  // a code with high nibble 1 is a device check, 2 a seek error
  function automatic logic [1:0] code_group(input logic [7:0] c);
    code_group = {c[7:4] == 4'h2, c[7:4] == 4'h1};
  endfunction

  // group of the next and of the held code; a function result cannot be indexed directly
  logic [1:0] grp_next;
  logic [1:0] grp_held;
  assign grp_next = code_group(code_next);
  assign grp_held = code_group(code_reg);

  // first fault wins; a fault in the clear cycle is caught, not lost
  always_comb begin
    code_next = code_reg;
    if (code_clear) begin
      code_next = new_code;
    end else if (code_reg == dfcm_pkg::CODE_NONE) begin
      code_next = new_code;
    end
  end

  // sticky status: set beats clear
  assign status_next = (status_reg & ~(wr_clear ? wdata_i[1:0] : 2'b00)) |
                       code_group(new_code);

  // ---------------------------------------------------------------
  // positioner tracking and timeout counter
  // ---------------------------------------------------------------
  always_comb begin
    pos_next   = pos_reg;
    timer_next = timer_reg + 32'h00000001;
    case (pos_reg)
      dfcm_pkg::DFCM_IDLE: begin
        timer_next = 32'h00000000;
        // a refused seek never starts moving
        if (rtz_cmd_i) begin
          pos_next = dfcm_pkg::DFCM_RTZ;
        end else if (seek_cmd_i && spd_ok) begin
          pos_next = dfcm_pkg::DFCM_SEEK;
        end
      end
      dfcm_pkg::DFCM_SEEK, dfcm_pkg::DFCM_RTZ: begin
        // end on completion or in the same cycle as the timeout is reported
        if (done || timer_full) begin
          pos_next   = dfcm_pkg::DFCM_IDLE;
          timer_next = 32'h00000000;
        end
      end
      default: begin
        pos_next   = dfcm_pkg::DFCM_IDLE;
        timer_next = 32'h00000000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos_reg   <= dfcm_pkg::DFCM_IDLE;
      timer_reg <= 32'h00000000;
    end else begin
      pos_reg   <= pos_next;
      timer_reg <= timer_next;
    end
  end

  // fault code and status
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_reg     <= dfcm_pkg::CODE_NONE;
      status_reg   <= 2'b00;
      seek_err_reg <= 1'b0;
    end else begin
      code_reg     <= code_next;
      status_reg   <= status_next;
      // seek error lingers until the held code is cleared
      seek_err_reg <= grp_next[1];
    end
  end

  // software registers; the clear bit is a strobe and does not stay set
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      control_reg <= dfcm_pkg::CONTROL_RESET;
      enable_reg  <= dfcm_pkg::ENABLE_RESET[1:0];
      rdata_reg   <= 8'h00;
    end else begin
      if (wr_control) begin
        control_reg <= {wdata_i[7:1], 1'b0};
      end
      if (wr_enable) begin
        enable_reg <= wdata_i[1:0];
      end
      rdata_reg <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o               = rdata_reg;
  assign fault_code_o          = code_reg;
  assign device_check_status_o = grp_held[0];
  assign seek_error_status_o   = grp_held[1];
  // write is held off while protected; combinational handshake-style flag
  assign write_refused_o       = write_cmd_i && protect;
  assign irq_o                 = |(status_reg & enable_reg);

endmodule // dfcm_monitor

// >>> dfcm_assertions.sv
// port-level assertion checker for the drive fault code monitor
module dfcm_assertions #(
  parameter longint RTZ_CYC  = 50,
  parameter longint SEEK_CYC = 20
) (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       seek_cmd_i,
  input wire logic       write_cmd_i,
  input wire logic [9:0] cylinder_address_register_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] fault_code_o,
  input wire logic       device_check_status_o,
  input wire logic       seek_error_status_o,
  input wire logic       write_refused_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  longint seek_cnt_reg; // cycles since the latest seek command
  // free counter, restarted by each seek so a timeout can be aged
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) seek_cnt_reg <= 0;
    else if (seek_cmd_i) seek_cnt_reg <= 0;
    else seek_cnt_reg <= seek_cnt_reg + 1;
  end
  protect_refuse_a: assert property (write_refused_o |-> write_cmd_i)
    else $error("write refused without a write command");
  protect_code_a: assert property (write_refused_o && fault_code_o == 8'h00
    |=> fault_code_o inside {8'h12, 8'h13, 8'h14, 8'h15}) else $error("protect code missing");
  dev_check_a: assert property (fault_code_o[7:4] == 4'h1
    |-> device_check_status_o && !seek_error_status_o) else $error("device check flag wrong");
  seek_err_a: assert property (fault_code_o[7:4] == 4'h2
    |-> seek_error_status_o && !device_check_status_o) else $error("seek error flag wrong");
  read_code_a: assert property ($past(rd_i) && $past(addr_i) == 4'h1
    |-> rdata_o == $past(fault_code_o)) else $error("code read back wrong");
  illegal_cyl_a: assert property (fault_code_o == 8'h27 && $past(fault_code_o) != 8'h27
    |-> $past(cylinder_address_register_i) > 10'h2E8) else $error("cylinder code without cause");
  not_speed_a: assert property (fault_code_o == 8'h23 && $past(fault_code_o) != 8'h23
    |-> $past(seek_cmd_i)) else $error("speed code without seek");
  first_hold_a: assert property ($past(fault_code_o) != 8'h00
    && fault_code_o != $past(fault_code_o)
    |-> $past(wr_i) && $past(addr_i) == 4'h0 && $past(wdata_i[0])) else $error("held code lost");
  seek_tmo_a: assert property (fault_code_o == 8'h22 && $past(fault_code_o) != 8'h22
    |-> seek_cnt_reg >= SEEK_CYC - 1) else $error("seek timeout too early");
endmodule // dfcm_assertions

bind dfcm_monitor dfcm_assertions #(.RTZ_CYC(RTZ_CYC), .SEEK_CYC(SEEK_CYC)) i_dfcm_assertions (
  .ref_clk_i, .nrst_i, .seek_cmd_i, .write_cmd_i, .cylinder_address_register_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .fault_code_o, .device_check_status_o,
  .seek_error_status_o, .write_refused_o);

// >>> dfcm_ctrl_model.sv
// behavioural disk controller issuing one-cycle commands to the monitor
module dfcm_ctrl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,              // start one command
  input  wire logic [2:0] op_i,              // 1 seek, 2 rtz, 3 read, 4 write
  input  wire logic [9:0] cyl_i,             // wanted cylinder
  input  wire logic       bad_i,             // let an out-of-range cylinder through
  output logic            seek_cmd_o  = 1'b0,
  output logic            rtz_cmd_o   = 1'b0,
  output logic            read_cmd_o  = 1'b0,
  output logic            write_cmd_o = 1'b0,
  output logic      [9:0] cyl_o       = 10'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  // commands are single-cycle pulses launched just after an edge
  always @(posedge ref_clk_i) begin
    seek_cmd_o  <= go_i && op_i == 3'h1;
    rtz_cmd_o   <= go_i && op_i == 3'h2;
    read_cmd_o  <= go_i && op_i == 3'h3;
    write_cmd_o <= go_i && op_i == 3'h4;
    // a sane controller clamps at the last cylinder; bad_i is the fault case
    cyl_o <= (cyl_i > 10'h2E8 && !bad_i) ? 10'h2E8 : cyl_i;
  end
endmodule // dfcm_ctrl_model

// >>> dfcm_monitor_bench.sv
// self-checking bench for the drive fault code monitor
module dfcm_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] PIN_OK = 13'h0312; // ready, on cylinder, speed good, seek done
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [12:0] pins      = PIN_OK; // packed status pin levels
  logic [7:0]  fpe       = 8'h00;
  logic        go        = 1'b0;
  logic        bad       = 1'b0;
  logic [2:0]  op        = 3'h0;
  logic [9:0]  cyl       = 10'h000;
  logic [3:0]  addr_i    = 4'h0;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        seek_c, rtz_c, read_c, write_c, dev_o, seek_o, refused_o, irq_o;
  logic [9:0]  cyl_c;
  logic [7:0]  rdata_o, fault_code_o;
  logic [7:0]  prev_code = 8'h00;
  logic [7:0]  exp_q[$]; // codes still waiting to appear
  int          err_count = 0;
  int          checks_done = 0;
  initial forever #4 ref_clk_i = ~ref_clk_i;
  dfcm_ctrl_model i_dfcm_ctrl_model (.ref_clk_i, .go_i(go), .op_i(op), .cyl_i(cyl), .bad_i(bad),
    .seek_cmd_o(seek_c), .rtz_cmd_o(rtz_c), .read_cmd_o(read_c), .write_cmd_o(write_c),
    .cyl_o(cyl_c));
  // short timeouts keep the run brief
  dfcm_monitor #(.RTZ_CYC(50), .SEEK_CYC(20)) i_dfcm_monitor (.ref_clk_i, .nrst_i,
    .seek_cmd_i(seek_c), .rtz_cmd_i(rtz_c), .read_cmd_i(read_c), .write_cmd_i(write_c),
    .cylinder_address_register_i(cyl_c), .write_active_i(pins[12]), .read_active_i(pins[11]),
    .offset_active_i(pins[10]), .ready_i(pins[9]), .on_cylinder_i(pins[8]),
    .write_unsafe_i(pins[7]), .file_protect_i(pins[6]), .multi_head_i(pins[5]),
    .speed_good_i(pins[4]), .guard_band_i(pins[3]), .linear_mode_i(pins[2]),
    .seek_done_i(pins[1]), .overshoot_i(pins[0]), .fine_position_error_i(fpe), .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .fault_code_o, .device_check_status_o(dev_o),
    .seek_error_status_o(seek_o), .write_refused_o(refused_o), .irq_o);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, want);
  endtask
  // back to healthy pins, then drop the held code
  task automatic clr();
    @(posedge ref_clk_i);
    pins <= PIN_OK;
    fpe <= 8'h00;
    cyl <= 10'h000;
    bad <= 1'b0;
    cyc(4);
    wr(4'h0, 8'h01);
    cyc(2);
    check(fault_code_o, 8'h00);
  endtask
  task automatic run(input logic [12:0] p, input logic [2:0] o, input logic [7:0] f,
                     input logic [9:0] c, input logic [7:0] want);
    @(posedge ref_clk_i);
    pins <= p;
    fpe <= f;
    cyl <= c;
    bad <= c > 10'h2E8;
    if (want != 8'h00) exp_q.push_back(want);
    cyc(4);
    if (o != 3'h0) begin
      go <= 1'b1;
      op <= o;
      @(posedge ref_clk_i);
      go <= 1'b0;
      #1 check({7'h00, refused_o}, {7'h00, o == 3'h4 && p[6]});
    end
    for (int i = 0; i < 100 && want != 8'h00 && fault_code_o === 8'h00; i++) cyc(1);
    cyc(want == 8'h00 ? 10 : 2);
    check(fault_code_o, want);
  endtask
  // watcher: each new code is matched against the oldest expectation
  always @(posedge ref_clk_i) begin
    #1;
    if (fault_code_o !== prev_code && fault_code_o !== 8'h00) begin
      if (exp_q.size() == 0) check(fault_code_o, 8'h00);
      else check(fault_code_o, exp_q.pop_front());
    end
    prev_code = fault_code_o;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    err_count++;
    finish_test();
  end
  initial begin
    logic [12:0] tp[12] = '{13'h0B12, 13'h0112, 13'h1312, 13'h1392, 13'h1332, 13'h0310,
                            13'h0310, 13'h0302, 13'h0318, 13'h031E, 13'h0317, 13'h0312};
    logic [2:0]  to[12] = '{3'h4, 3'h3, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
    logic [7:0]  tw[12] = '{8'h12, 8'h12, 8'h13, 8'h14, 8'h16, 8'h21,
                            8'h22, 8'h23, 8'h24, 8'h25, 8'h2B, 8'h27};
    void'($urandom(32'hBB8EDE7A));
    cyc(4);
    nrst_i <= 1'b1;
    run(13'h0352, 3'h4, 8'h00, 10'h000, 8'h15);
    rd(4'h1, 8'h15);
    rd(4'h2, 8'h01);
    rd(4'hF, 8'h00);
    check({7'h00, dev_o}, 8'h01);
    check({7'h00, irq_o}, 8'h00);
    wr(4'h4, 8'h03);
    cyc(2);
    check({7'h00, irq_o}, 8'h01);
    pins <= 13'h1392;
    cyc(10);
    check(fault_code_o, 8'h15);
    clr();
    wr(4'h3, 8'h03);
    cyc(2);
    check({7'h00, irq_o}, 8'h00);
    foreach (tw[i]) begin
      clr();
      run(tp[i], to[i], (i == 2) ? 8'd93 : 8'h00, (i == 11) ? 10'd745 : 10'h000, tw[i]);
    end
    clr();
    wr(4'h0, 8'h02); // mask the cylinder check
    run(13'h0312, 3'h0, 8'h00, 10'd745, 8'h00);
    rd(4'h5, 8'hE9);
    clr();
    run(13'h1312, 3'h4, 8'($urandom_range(92)), 10'($urandom_range(744)), 8'h00);
    check(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // dfcm_monitor_bench
